// ---- core/floppy_command_parameter_decode.sv ----
// command parameter decoder: sector sequencing, gaps, size, head load timing, config retain
//
// Functional notes
// - stop sector sequencing on a track after the end sector number.
// - in perpendicular mode the second-field spacing sets gap 2 length.
// - intersector spacing length is the gap 3 size, sync field excluded.
// - head side select gives head 0 or 1, as in sector ID.
// - after head load wait the settle delay before read or write.
// - hold head loaded for release delay after execution, then unload.
// - retain flag keeps queue enable, threshold, precomp track over software reset.
// - density select one is double density, zero single density.
// - multi-side continue runs head 0 last sector into head 1 first.
// - size code 0 is 128 bytes with short length; else 128 shl code.
// - target cylinder is the seek destination cylinder.
// - size code 0 passes short count on reads, zero fills on writes.
// - queue enable is active low, default disabled.
`timescale 1ns/1ps
module floppy_command_parameter_decode #(
  parameter int CNT_W = fdc_param_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_load,
  input wire logic [7:0] end_sector_number,
  input wire logic [7:0] gap2_spacing,
  input wire logic [7:0] intersector_spacing_length,
  input wire logic head_side_select,
  input wire logic [7:0] start_sector,
  input wire logic [fdc_param_pkg::SIZE_W-1:0] size_code,
  input wire logic [7:0] short_sector_length,
  input wire logic [7:0] target_cylinder,
  input wire logic double_density_select,
  input wire logic multi_side_continue,
  input wire logic perpendicular_mode,
  input wire logic sector_done,
  input wire logic head_load_req,
  input wire logic exec_end,
  input wire logic [7:0] head_settle_delay,
  input wire logic [7:0] head_release_delay,
  input wire logic [3:0] rate_scale,
  input wire logic cfg_write,
  input wire logic cfg_queue_enable_low,
  input wire logic [7:0] cfg_queue_threshold,
  input wire logic [7:0] cfg_precomp_start_track,
  input wire logic cfg_retain,
  input wire logic soft_reset,
  output logic [7:0] cur_sector,
  output logic cur_head,
  output logic track_end,
  output logic [7:0] gap2_len,
  output logic [7:0] gap3_len,
  output logic double_density,
  output logic [15:0] sector_bytes,
  output logic [15:0] host_bytes,
  output logic zero_fill,
  output logic [7:0] seek_cylinder,
  output logic head_loaded,
  output logic rw_ready,
  output logic queue_enable_low,
  output logic [7:0] queue_threshold,
  output logic [7:0] precomp_start_track,
  output logic retain_ff_out
);
  import fdc_param_pkg::*;

  // ****************************************
  // command parameters latched at command load
  // ****************************************
  logic [7:0] end_sector_ff, nxt_end_sector;
  logic [7:0] cur_sector_ff, nxt_cur_sector;
  logic cur_head_ff, nxt_cur_head;
  logic track_end_ff, nxt_track_end;
  logic mscont_ff, nxt_mscont;
  logic [7:0] gap2_ff, nxt_gap2;
  logic [7:0] gap3_ff, nxt_gap3;
  logic dd_ff, nxt_dd;
  logic [15:0] sbytes_ff, nxt_sbytes;
  logic [15:0] hbytes_ff, nxt_hbytes;
  logic zfill_ff, nxt_zfill;
  logic [7:0] seek_ff, nxt_seek;

  always_comb begin
    nxt_end_sector = end_sector_ff;
    nxt_cur_sector = cur_sector_ff;
    nxt_cur_head = cur_head_ff;
    nxt_track_end = track_end_ff;
    nxt_mscont = mscont_ff;
    nxt_gap2 = gap2_ff;
    nxt_gap3 = gap3_ff;
    nxt_dd = dd_ff;
    nxt_sbytes = sbytes_ff;
    nxt_hbytes = hbytes_ff;
    nxt_zfill = zfill_ff;
    nxt_seek = seek_ff;
    if (cmd_load) begin
      nxt_end_sector = end_sector_number;
      nxt_cur_sector = start_sector;
      nxt_cur_head = head_side_select;
      nxt_track_end = 1'b0;
      nxt_mscont = multi_side_continue;
      // gap 2 only changes in perpendicular mode; otherwise the previously latched gap 2 value stays
      nxt_gap2 = perpendicular_mode ? gap2_spacing : gap2_ff;
      nxt_gap3 = intersector_spacing_length;
      nxt_dd = double_density_select;
      nxt_sbytes = BASE_SECTOR_BYTES << size_code;
      // size codes the drive cannot hold are the host's problem, not flagged
      if (size_code == '0) begin
        nxt_hbytes = {8'h00, short_sector_length};
        nxt_zfill = 1'b1;
      end else begin
        nxt_hbytes = BASE_SECTOR_BYTES << size_code;
        nxt_zfill = 1'b0;
      end
      nxt_seek = target_cylinder;
    end else if (sector_done && !track_end_ff) begin
      if (cur_sector_ff == end_sector_ff) begin
        if (mscont_ff && !cur_head_ff) begin
          nxt_cur_head = 1'b1;
          nxt_cur_sector = FIRST_SECTOR;
        end else begin
          nxt_track_end = 1'b1;
        end
      end else begin
        nxt_cur_sector = cur_sector_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      end_sector_ff <= 8'h00;
      cur_sector_ff <= FIRST_SECTOR;
      cur_head_ff <= 1'b0;
      track_end_ff <= 1'b0;
      mscont_ff <= 1'b0;
      gap2_ff <= 8'h00;
      gap3_ff <= 8'h00;
      dd_ff <= 1'b0;
      sbytes_ff <= BASE_SECTOR_BYTES;
      hbytes_ff <= BASE_SECTOR_BYTES;
      zfill_ff <= 1'b0;
      seek_ff <= 8'h00;
    end else begin
      end_sector_ff <= nxt_end_sector;
      cur_sector_ff <= nxt_cur_sector;
      cur_head_ff <= nxt_cur_head;
      track_end_ff <= nxt_track_end;
      mscont_ff <= nxt_mscont;
      gap2_ff <= nxt_gap2;
      gap3_ff <= nxt_gap3;
      dd_ff <= nxt_dd;
      sbytes_ff <= nxt_sbytes;
      hbytes_ff <= nxt_hbytes;
      zfill_ff <= nxt_zfill;
      seek_ff <= nxt_seek;
    end
  end

  // ****************************************
  // head load, settle and release sequencing
  // ****************************************
  head_state_t hstate_ff, nxt_hstate;
  logic rw_ready_ff, nxt_rw_ready;
  logic head_loaded_ff, nxt_head_loaded;
  logic tmr_start;
  logic [CNT_W-1:0] tmr_load;
  logic tmr_done;

  // delay counts are specify values times rate scale times unit cycles
  function automatic logic [CNT_W-1:0] scale_delay(input logic [7:0] val, input logic [3:0] rate);
    logic [CNT_W+15:0] prod;
    prod = (CNT_W+16)'(val) * (CNT_W+16)'(rate) * (CNT_W+16)'(UNIT_CYCLES);
    return prod[CNT_W-1:0];
  endfunction

  always_comb begin
    nxt_hstate = hstate_ff;
    nxt_rw_ready = rw_ready_ff;
    tmr_start = 1'b0;
    tmr_load = '0;
    unique case (hstate_ff)
      head_idle_t_e: begin
        if (head_load_req) begin
          nxt_hstate = head_settle_e;
          tmr_start = 1'b1;
          tmr_load = scale_delay(head_settle_delay, rate_scale);
        end
      end
      head_settle_e: begin
        if (tmr_done) begin
          nxt_hstate = head_loaded_e;
          nxt_rw_ready = 1'b1;
        end
      end
      head_loaded_e: begin
        if (exec_end) begin
          nxt_hstate = head_release_e;
          nxt_rw_ready = 1'b0;
          tmr_start = 1'b1;
          tmr_load = scale_delay(head_release_delay, rate_scale);
        end
      end
      head_release_e: begin
        // a new request while still loaded skips the settle wait
        if (head_load_req) begin
          nxt_hstate = head_loaded_e;
          nxt_rw_ready = 1'b1;
        end else if (tmr_done) begin
          nxt_hstate = head_idle_t_e;
        end
      end
    endcase
    nxt_head_loaded = (nxt_hstate != head_idle_t_e);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hstate_ff <= head_idle_t_e;
      rw_ready_ff <= 1'b0;
      head_loaded_ff <= 1'b0;
    end else begin
      hstate_ff <= nxt_hstate;
      rw_ready_ff <= nxt_rw_ready;
      head_loaded_ff <= nxt_head_loaded;
    end
  end

  delay_timer #(.CNT_W(CNT_W)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(tmr_start),
    .load_cycles(tmr_load),
    .done(tmr_done)
  );

  // ****************************************
  // configuration with retain over software reset
  // ****************************************
  logic qen_low_ff, nxt_qen_low;
  logic [7:0] qthr_ff, nxt_qthr;
  logic [7:0] precomp_ff, nxt_precomp;
  logic retain_ff, nxt_retain;

  always_comb begin
    nxt_qen_low = qen_low_ff;
    nxt_qthr = qthr_ff;
    nxt_precomp = precomp_ff;
    nxt_retain = retain_ff;
    if (cfg_write) begin
      nxt_qen_low = cfg_queue_enable_low;
      nxt_qthr = cfg_queue_threshold;
      nxt_precomp = cfg_precomp_start_track;
      nxt_retain = cfg_retain;
    end else if (soft_reset && !retain_ff) begin
      nxt_qen_low = QUEUE_EN_LOW_DEFAULT;
      nxt_qthr = QUEUE_THR_DEFAULT;
      nxt_precomp = PRECOMP_DEFAULT;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      qen_low_ff <= QUEUE_EN_LOW_DEFAULT;
      qthr_ff <= QUEUE_THR_DEFAULT;
      precomp_ff <= PRECOMP_DEFAULT;
      retain_ff <= 1'b0;
    end else begin
      qen_low_ff <= nxt_qen_low;
      qthr_ff <= nxt_qthr;
      precomp_ff <= nxt_precomp;
      retain_ff <= nxt_retain;
    end
  end

  assign cur_sector = cur_sector_ff;
  assign cur_head = cur_head_ff;
  assign track_end = track_end_ff;
  assign gap2_len = gap2_ff;
  assign gap3_len = gap3_ff;
  assign double_density = dd_ff;
  assign sector_bytes = sbytes_ff;
  assign host_bytes = hbytes_ff;
  assign zero_fill = zfill_ff;
  assign seek_cylinder = seek_ff;
  assign head_loaded = head_loaded_ff;
  assign rw_ready = rw_ready_ff;
  assign queue_enable_low = qen_low_ff;
  assign queue_threshold = qthr_ff;
  assign precomp_start_track = precomp_ff;
  assign retain_ff_out = retain_ff;
endmodule

// ---- core/fdc_param_pkg.sv ----
// constants shared by the command parameter decoder and its delay timer
package fdc_param_pkg;
  localparam int BYTE_W = 8;
  localparam int SIZE_W = 3;
  localparam int CNT_W = 20;
  localparam logic [2:0] SIZE_CODE_MAX = 3'h7;
  localparam logic [15:0] BASE_SECTOR_BYTES = 16'h0080;
  localparam logic [7:0] FIRST_SECTOR = 8'h01;
  localparam logic [7:0] QUEUE_THR_DEFAULT = 8'h00;
  localparam logic [7:0] PRECOMP_DEFAULT = 8'h00;
  localparam logic QUEUE_EN_LOW_DEFAULT = 1'b1;
  // delay unit in microseconds at the 1 Mbit rate, scaled per rate
  localparam int DELAY_UNIT_US = 1;
  localparam int CLK_MHZ = 10;
  localparam int UNIT_CYCLES = DELAY_UNIT_US * CLK_MHZ;
  typedef enum logic [1:0] {head_idle_t_e, head_settle_e, head_loaded_e, head_release_e} head_state_t;
endpackage

// ---- core/delay_timer.sv ----
// down counter producing one settle or release delay in scaled units
`timescale 1ns/1ps
module delay_timer #(
  parameter int CNT_W = fdc_param_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [CNT_W-1:0] load_cycles,
  output logic done
);
  import fdc_param_pkg::*;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;
  logic done_ff;
  logic nxt_done;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = load_cycles;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (cnt_ff == '0) begin
        nxt_run = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule

// ---- verif/fcpd_checker.sv ----
// port assertions for the command parameter decoder
`timescale 1ns/1ps
module fcpd_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_load,
  input wire logic [7:0] gap2_spacing,
  input wire logic [7:0] intersector_spacing_length,
  input wire logic head_side_select,
  input wire logic [fdc_param_pkg::SIZE_W-1:0] size_code,
  input wire logic [7:0] target_cylinder,
  input wire logic double_density_select,
  input wire logic perpendicular_mode,
  input wire logic head_load_req,
  input wire logic exec_end,
  input wire logic cfg_write,
  input wire logic soft_reset,
  input wire logic [7:0] cur_sector,
  input wire logic cur_head,
  input wire logic track_end,
  input wire logic [7:0] gap2_len,
  input wire logic [7:0] gap3_len,
  input wire logic double_density,
  input wire logic [15:0] sector_bytes,
  input wire logic [7:0] seek_cylinder,
  input wire logic head_loaded,
  input wire logic rw_ready,
  input wire logic queue_enable_low,
  input wire logic [7:0] queue_threshold,
  input wire logic [7:0] precomp_start_track,
  input wire logic retain_ff_out
);
  import fdc_param_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ****
  // checks
  // ****
  // release delay is at least two cycles, so the head is still loaded one cycle on
  sequence unload_s;
    !rw_ready ##1 head_loaded;
  endsequence
  sequence cfg_kept_s;
    $stable(queue_enable_low) && $stable(queue_threshold) && $stable(precomp_start_track);
  endsequence
  gap3_len_a: assert property (cmd_load |=> gap3_len == $past(intersector_spacing_length))
    else $error("gap 3 length not taken");
  gap2_len_a: assert property (cmd_load && perpendicular_mode |=> gap2_len == $past(gap2_spacing))
    else $error("gap 2 length not taken");
  density_mode_a: assert property (cmd_load |=> double_density == $past(double_density_select))
    else $error("density mode wrong");
  head_seek_a: assert property (cmd_load |=>
    cur_head == $past(head_side_select) && seek_cylinder == $past(target_cylinder))
    else $error("head or seek cylinder wrong");
  sector_size_a: assert property (cmd_load |=> sector_bytes == BASE_SECTOR_BYTES << $past(size_code))
    else $error("sector size wrong");
  track_stop_a: assert property (track_end && !cmd_load |=> $stable(cur_sector))
    else $error("sector moved past track end");
  retain_hold_a: assert property (soft_reset && !cfg_write && retain_ff_out |=> cfg_kept_s)
    else $error("retained config lost");
  cfg_default_a: assert property (soft_reset && !cfg_write && !retain_ff_out |=>
    queue_enable_low == QUEUE_EN_LOW_DEFAULT && queue_threshold == QUEUE_THR_DEFAULT)
    else $error("config defaults not restored");
  head_load_a: assert property (head_load_req |=> head_loaded)
    else $error("head not loaded");
  head_release_a: assert property (exec_end && head_loaded && !head_load_req |=> unload_s)
    else $error("head released early");
  settle_wait_a: assert property ($rose(head_loaded) |-> !rw_ready ##1 !rw_ready)
    else $error("read or write allowed before settle");
endmodule
bind floppy_command_parameter_decode fcpd_checker chk (.*);

// ---- verif/drive_model.sv ----
// drive stand-in: reports a finished sector every pace+1 cycles while spinning
`timescale 1ns/1ps
module drive_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [3:0] pace,
  output logic sector_done
);
  // ****
  // sector pacing
  // ****
  logic [3:0] gap_ff;
  logic [3:0] nxt_gap;
  logic nxt_done;
  // pace zero gives back-to-back sectors, the hardest case for the sequencer
  always_comb begin
    nxt_done = run && gap_ff == 4'h0;
    nxt_gap = (nxt_done || !run) ? pace : gap_ff - 4'h1;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 4'h0;
      sector_done <= 1'b0;
    end else begin
      gap_ff <= nxt_gap;
      sector_done <= nxt_done;
    end
  end
endmodule

// ---- verif/floppy_command_parameter_decode_test.sv ----
// self-checking bench for the command parameter decoder
`timescale 1ns/1ps
module floppy_command_parameter_decode_test;
  import fdc_param_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_load = 1'b0, head_side_select = 1'b0, double_density_select = 1'b0, multi_side_continue = 1'b0;
  logic perpendicular_mode = 1'b0, head_load_req = 1'b0, exec_end = 1'b0, cfg_write = 1'b0, cfg_retain = 1'b0;
  logic cfg_queue_enable_low = 1'b0, soft_reset = 1'b0, run = 1'b0, sector_done;
  logic [7:0] end_sector_number = 8'h01, gap2_spacing = 8'h00, intersector_spacing_length = 8'h00;
  logic [7:0] start_sector = 8'h01, short_sector_length = 8'h00, target_cylinder = 8'h00, g2 = 8'h00;
  logic [7:0] head_settle_delay = 8'h01, head_release_delay = 8'h01, cfg_queue_threshold = 8'h00;
  logic [7:0] cfg_precomp_start_track = 8'h00, cur_sector, gap2_len, gap3_len, seek_cylinder;
  logic [7:0] queue_threshold, precomp_start_track;
  logic [SIZE_W-1:0] size_code = 3'h0;
  logic [3:0] rate_scale = 4'h1, pace = 4'h0;
  logic [15:0] sector_bytes, host_bytes;
  logic cur_head, track_end, double_density, zero_fill, head_loaded, rw_ready, queue_enable_low, retain_ff_out;
  int fails = 0, tests_run = 0, n, s;
  floppy_command_parameter_decode dut (.*);
  drive_model drv (.mclk(mclk), .rst_n(rst_n), .run(run), .pace(pace), .sector_done(sector_done));
  always #50 mclk = ~mclk;
  // ****
  // helpers
  // ****
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // sector size for a code: 128 doubled code times
  function automatic logic [15:0] exp_bytes(input logic [2:0] code);
    return BASE_SECTOR_BYTES << code;
  endfunction
  // cycles from a taken request to the answer: scaled delay plus load and done stages
  function automatic int exp_span(input logic [7:0] val, input logic [3:0] rate);
    return int'(val) * int'(rate) * UNIT_CYCLES + 2;
  endfunction
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // counts cycles until the head is ready (rel=0) or unloaded (rel=1)
  task automatic span(input logic rel);
    n = 0;
    while ((rel ? head_loaded !== 1'b0 : rw_ready !== 1'b1) && n < 9000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic load(input logic ms, input logic hd, input logic [2:0] code);
    @(posedge mclk);
    {cmd_load, multi_side_continue, head_side_select, size_code} <= {1'b1, ms, hd, code};
    {gap2_spacing, intersector_spacing_length} <= 16'($urandom);
    {short_sector_length, target_cylinder} <= 16'($urandom);
    {double_density_select, perpendicular_mode} <= 2'($urandom);
    @(posedge mclk);
    cmd_load <= 1'b0;
    @(posedge mclk);
    #1;
    g2 = perpendicular_mode ? gap2_spacing : g2;
    chk(16'(gap2_len), 16'(g2));
    chk(16'(gap3_len), 16'(intersector_spacing_length));
    chk(16'(cur_head), 16'(hd));
    chk(16'(double_density), 16'(double_density_select));
    chk(16'(seek_cylinder), 16'(target_cylinder));
    chk(sector_bytes, exp_bytes(code));
    chk(host_bytes, code == 3'h0 ? 16'(short_sector_length) : exp_bytes(code));
    chk(16'(zero_fill), 16'(code == 3'h0));
  endtask
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h87C2FABF));
    repeat (10) @(posedge mclk);
    chk(16'(cur_sector), 16'(FIRST_SECTOR));
    chk(16'(queue_enable_low), 16'(QUEUE_EN_LOW_DEFAULT));
    rst_n <= 1'b1;
    for (int c = 0; c <= SIZE_CODE_MAX; c++) begin
      load(1'b0, 1'($urandom), 3'(c));
    end
    for (int ms = 0; ms < 2; ms++) begin
      @(posedge mclk);
      start_sector <= 8'h01 + 8'($urandom_range(0, 3));
      end_sector_number <= 8'h05 + 8'($urandom_range(0, 20));
      pace <= 4'($urandom_range(0, 3));
      load(1'(ms), 1'b0, 3'($urandom_range(0, 7)));
      run <= 1'b1;
      span(1'b1);
      while (track_end !== 1'b1 && n < 3000) begin
        @(posedge mclk);
        #1;
        n++;
      end
      repeat (4) @(posedge mclk);
      #1;
      run <= 1'b0;
      chk(16'(cur_sector), 16'(end_sector_number));
      chk(16'(cur_head), 16'(ms));
      chk(16'(track_end), 16'h0001);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      {head_settle_delay, head_release_delay} <= {8'($urandom_range(1, 4)), 8'($urandom_range(0, 4))};
      rate_scale <= 4'($urandom_range(1, 3));
      @(posedge mclk);
      head_load_req <= 1'b1;
      @(posedge mclk);
      head_load_req <= 1'b0;
      #1;
      chk(16'(head_loaded), 16'h0001);
      s = exp_span(head_settle_delay, rate_scale);
      span(1'b0);
      chk(16'(n), 16'(s));
      @(posedge mclk);
      exec_end <= 1'b1;
      @(posedge mclk);
      exec_end <= 1'b0;
      #1;
      s = exp_span(head_release_delay, rate_scale);
      chk(16'(rw_ready), 16'h0000);
      if (k == 1) begin
        // a request inside the release window takes the still loaded head back with no settle wait
        @(posedge mclk);
        head_load_req <= 1'b1;
        @(posedge mclk);
        head_load_req <= 1'b0;
        #1;
        chk(16'(rw_ready), 16'h0001);
        @(posedge mclk);
        exec_end <= 1'b1;
        @(posedge mclk);
        exec_end <= 1'b0;
        #1;
        chk(16'(rw_ready), 16'h0000);
      end
      span(1'b1);
      chk(16'(n), 16'(s));
    end
    // configuration followed at once by a software reset, retained then not
    for (int keep = 1; keep >= 0; keep--) begin
      @(posedge mclk);
      {cfg_write, cfg_retain, cfg_queue_enable_low} <= {1'b1, 1'(keep), 1'($urandom)};
      {cfg_queue_threshold, cfg_precomp_start_track} <= 16'($urandom);
      @(posedge mclk);
      {cfg_write, soft_reset} <= 2'b01;
      @(posedge mclk);
      soft_reset <= 1'b0;
      #1;
      chk(16'(queue_enable_low), 16'(keep ? cfg_queue_enable_low : QUEUE_EN_LOW_DEFAULT));
      chk(16'(queue_threshold), 16'(keep ? cfg_queue_threshold : QUEUE_THR_DEFAULT));
      chk(16'(precomp_start_track), 16'(keep ? cfg_precomp_start_track : PRECOMP_DEFAULT));
      chk(16'(retain_ff_out), 16'(keep));
    end
    // a write in the same cycle as a software reset wins over the defaults
    @(posedge mclk);
    {cfg_write, soft_reset, cfg_retain, cfg_queue_enable_low} <= {3'h6, 1'($urandom)};
    {cfg_queue_threshold, cfg_precomp_start_track} <= 16'($urandom);
    @(posedge mclk);
    {cfg_write, soft_reset} <= 2'h0;
    #1;
    chk(16'(queue_enable_low), 16'(cfg_queue_enable_low));
    chk(16'(queue_threshold), 16'(cfg_queue_threshold));
    chk(16'(precomp_start_track), 16'(cfg_precomp_start_track));
    chk(16'(retain_ff_out), 16'h0000);
    end_of_test();
  end
  // the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    end_of_test();
  end
endmodule
